// ---- sfpec_pkg.sv ----
// Constants shared by the flash program and erase sequencer.
package sfpec_pkg;
  // Command opcodes.
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_CLFSR  = 8'h50;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_RDFSR  = 8'h70;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_DPP    = 8'ha2;
  localparam logic [7:0] OP_XDPP   = 8'hd2;
  localparam logic [7:0] OP_QPP    = 8'h32;
  localparam logic [7:0] OP_XQPP   = 8'h38;
  localparam logic [7:0] OP_SSE_A  = 8'h52;
  localparam logic [7:0] OP_SSE_B  = 8'h20;
  localparam logic [7:0] OP_SE     = 8'hd8;
  localparam logic [7:0] OP_BE_A   = 8'hc7;
  localparam logic [7:0] OP_BE_B   = 8'h60;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  // Lane protocol selection.
  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  // Flag status bit positions and reset value.
  localparam int FSR_READY    = 7;
  localparam int FSR_ERS_SUSP = 6;
  localparam int FSR_ERS_ERR  = 5;
  localparam int FSR_PRG_ERR  = 4;
  localparam int FSR_PRG_SUSP = 2;
  localparam int FSR_PROT     = 1;
  localparam logic [7:0] FSR_RST = 8'h80;
  // Frame layout: opcode byte, three address bytes, then data.
  localparam logic [2:0] BYTE_DATA = 3'h4;
  // Erase kinds.
  localparam logic [1:0] ERS_SUB  = 2'h0;
  localparam logic [1:0] ERS_SECT = 2'h1;
  localparam logic [1:0] ERS_BULK = 2'h2;
  // Data buffer shape.
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
  // Self-timed durations and their cycle counts at 20 MHz.
  localparam int unsigned CLK_KHZ                 = 20000;
  localparam int unsigned PAGE_PROGRAM_TIME_US    = 500;
  localparam int unsigned SUBSECTOR_ERASE_TIME_MS = 50;
  localparam int unsigned SECTOR_ERASE_TIME_MS    = 200;
  localparam int unsigned BULK_ERASE_TIME_MS      = 60000;
  localparam int unsigned PP_CYC  = PAGE_PROGRAM_TIME_US * CLK_KHZ / 1000;
  localparam int unsigned SSE_CYC = SUBSECTOR_ERASE_TIME_MS * CLK_KHZ;
  localparam int unsigned SE_CYC  = SECTOR_ERASE_TIME_MS * CLK_KHZ;
  localparam int unsigned BE_CYC  = BULK_ERASE_TIME_MS * CLK_KHZ;
  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_PROG  = 4'h2,
    S_ERASE = 4'h4,
    S_SUSP  = 4'h8
  } sfpec_state_e;
endpackage

// ---- sfpec_top.sv ----
// Serial flash program and erase sequencer with its page data buffer.
// Behaviour
// - Opcode 50h clears erase, program and protection error flags.
// - Clear-flag command arrives on the active lanes and ends when select rises.
// - Select rising off a byte boundary: no execution, no flag, latch kept.
// - Address bits are captured on rising serial clock edges.
// - Program to a protected sector: not executed, latch kept, flags 1 and 4.
// - Program timeout clears the latch and sets the program failure flag.
// - Page program 02h only clears bits from 1 to 0.
// - Dual fast program A2h and extended dual D2h are accepted.
// - Quad fast program 32h and extended quad 38h are accepted.
// - Program holds write-in-progress at 1; latch clears on completion or timeout.
// - Erase sets bits to 1; ignored silently while the latch is clear.
// - Erase of a protected subsector: not executed, latch kept, flags 1 and 5.
// - Erase drives controller-ready 0 and busy 1; completion clears busy and sets ready.
// - Erase timeout clears the latch and sets the erase error flag.
// - Subsector 52h/20h and sector D8h erase fill the addressed unit with FFh.
// - Subsector and sector erase can be suspended and resumed.
// - Bulk erase C7h/60h fills the array; any lock blocks it with flags 1 and 5.
// - Program and erase run self-timed after select rises, each its own time.
// - Opcode 06h sets the write enable latch and 04h clears it unless the protection flag is set.
// - Status and flag status stay readable at any time, even while busy.
`timescale 1ns/1ps

module sfpec_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp;
  logic [AW:0]  rp;

  // Full and empty come from pointers carrying one extra wrap bit.
  assign in_ready_o  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
  assign out_valid_o = (wp != rp);
  assign out_data_o  = mem[rp[AW-1:0]];

  // Pointers move on accepted transfers; flush empties the buffer.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
    end else if (flush_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid_i && in_ready_o) begin
        wp <= wp + 1'b1;
      end
      if (out_valid_o && out_ready_i) begin
        rp <= rp + 1'b1;
      end
    end
  end

  // Storage is written without reset.
  always_ff @(posedge clk_i) begin
    if (in_valid_i && in_ready_o && !flush_i) begin
      mem[wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module sfpec_top #(
  parameter int unsigned PP_CYC  = sfpec_pkg::PP_CYC,
  parameter int unsigned SSE_CYC = sfpec_pkg::SSE_CYC,
  parameter int unsigned SE_CYC  = sfpec_pkg::SE_CYC,
  parameter int unsigned BE_CYC  = sfpec_pkg::BE_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sel_n_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  dq_i,
  input  wire logic [1:0]  proto_i,
  input  wire logic        target_locked_i,
  input  wire logic        any_locked_i,
  input  wire logic        op_timeout_i,
  input  wire logic        mem_ready_i,
  output logic             wel_o,
  output logic             wip_o,
  output logic [7:0]       flag_status_o,
  output logic             mem_we_o,
  output logic [23:0]      mem_addr_o,
  output logic [7:0]       mem_clr_mask_o,
  output logic             erase_go_o,
  output logic [1:0]       erase_kind_o,
  output logic [23:0]      erase_addr_o
);
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [5:0]  s1;
  logic [5:0]  s2;
  logic        sel_q;
  logic        sck_q;
  logic [2:0]  bitcnt;
  logic [2:0]  byte_cnt;
  logic [7:0]  sh;
  logic [7:0]  op;
  logic [23:0] addr;
  logic [23:0] paddr;
  logic [31:0] tmr;
  logic        wel;
  logic        wip;
  logic [7:0]  fsr;
  logic        susp_prog;
  logic        mem_we;
  logic [23:0] maddr;
  logic [7:0]  mclr;
  logic        ers_go;
  logic [1:0]  ekind;
  logic [23:0] eaddr;
  logic        f_ready;
  logic        f_valid;
  logic [7:0]  f_data;
  sfpec_pkg::sfpec_state_e st;

  // Lane count for the next bits, from protocol, opcode and frame position.
  function automatic logic [2:0] lanes(input logic [1:0] pr, input logic [7:0] opc,
                                       input logic [2:0] bc);
    logic [2:0] w;
    w = 3'h1;
    if (pr == sfpec_pkg::PROTO_DUAL) begin
      w = 3'h2;
    end else if (pr == sfpec_pkg::PROTO_QUAD) begin
      w = 3'h4;
    end else if (bc != 3'h0) begin
      if (opc == sfpec_pkg::OP_XDPP ||
          (bc == sfpec_pkg::BYTE_DATA && opc == sfpec_pkg::OP_DPP)) begin
        w = 3'h2;
      end else if (opc == sfpec_pkg::OP_XQPP ||
                   (bc == sfpec_pkg::BYTE_DATA && opc == sfpec_pkg::OP_QPP)) begin
        w = 3'h4;
      end
    end
    return w;
  endfunction

  // Opcode-class decoding used by the byte path and the sequencer.
  wire is_prog  = op == sfpec_pkg::OP_PP || op == sfpec_pkg::OP_DPP ||
                  op == sfpec_pkg::OP_XDPP || op == sfpec_pkg::OP_QPP ||
                  op == sfpec_pkg::OP_XQPP;
  wire is_bulk  = op == sfpec_pkg::OP_BE_A || op == sfpec_pkg::OP_BE_B;
  wire is_sub   = op == sfpec_pkg::OP_SSE_A || op == sfpec_pkg::OP_SSE_B;
  wire is_erase = is_sub || op == sfpec_pkg::OP_SE || is_bulk;

  // Edge detection on the synchronised link pins.
  wire sel_fall = !s2[4] && sel_q;
  wire sel_rise = s2[4] && !sel_q;
  wire sck_rise = s2[5] && !sck_q && !s2[4];
  wire [2:0] w  = lanes(proto_i, op, byte_cnt);
  wire [3:0] nb = {1'b0, bitcnt} + {1'b0, w};
  wire [7:0] nsh = (w == 3'h1) ? {sh[6:0], s2[0]} :
                   (w == 3'h2) ? {sh[5:0], s2[1:0]} : {sh[3:0], s2[3:0]};
  wire byte_done = sck_rise && nb[3];
  wire aligned   = (bitcnt == 3'h0) && (byte_cnt != 3'h0);
  wire idle      = (st == sfpec_pkg::S_IDLE);
  wire push      = byte_done && idle && wel && is_prog && (byte_cnt == sfpec_pkg::BYTE_DATA);

  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Two-stage synchronisers for clock, select and data lanes, plus edge history.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1    <= 6'h10;
      s2    <= 6'h10;
      sel_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      s1    <= {sclk_i, sel_n_i, dq_i};
      s2    <= s1;
      sel_q <= s2[4];
      sck_q <= s2[5];
    end
  end

  // Byte assembly: opcode first, then three address bytes, then data.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt   <= 3'h0;
      byte_cnt <= 3'h0;
      sh       <= 8'h00;
      op       <= 8'h00;
      addr     <= 24'h000000;
    end else if (sel_fall) begin
      bitcnt   <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sck_rise) begin
      sh     <= nsh;
      bitcnt <= nb[2:0];
      if (nb[3]) begin
        if (byte_cnt == 3'h0) begin
          op <= nsh;
        end else if (byte_cnt < sfpec_pkg::BYTE_DATA) begin
          addr <= {addr[15:0], nsh};
        end
        if (byte_cnt != sfpec_pkg::BYTE_DATA) begin
          byte_cnt <= byte_cnt + 3'h1;
        end
      end
    end
  end

  // Page data buffer between the link and the array write port.
  sfpec_fifo #(
    .W (sfpec_pkg::FIFO_W),
    .D (sfpec_pkg::FIFO_D)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n),
    .flush_i     (sel_fall && idle),
    .in_valid_i  (push),
    .in_ready_o  (f_ready),
    .in_data_i   (nsh),
    .out_valid_o (f_valid),
    .out_ready_i (st == sfpec_pkg::S_PROG && mem_ready_i),
    .out_data_o  (f_data)
  );

  // Array write port: each byte only clears the bits that are zero in the data.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_we <= 1'b0;
      maddr  <= 24'h000000;
      mclr   <= 8'h00;
      paddr  <= 24'h000000;
    end else begin
      mem_we <= f_valid && st == sfpec_pkg::S_PROG && mem_ready_i;
      if (sel_rise && idle) begin
        paddr <= addr;
      end else if (f_valid && st == sfpec_pkg::S_PROG && mem_ready_i) begin
        maddr <= paddr;
        mclr  <= ~f_data;
        paddr <= paddr + 24'h000001;
      end
    end
  end

  // Command execution, latch, status flags and the self-timed operation timer.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st        <= sfpec_pkg::S_IDLE;
      tmr       <= 32'h0;
      wel       <= 1'b0;
      wip       <= 1'b0;
      fsr       <= sfpec_pkg::FSR_RST;
      susp_prog <= 1'b0;
      ers_go    <= 1'b0;
      ekind     <= sfpec_pkg::ERS_SUB;
      eaddr     <= 24'h000000;
    end else begin
      ers_go <= 1'b0;
      if (sel_rise && aligned && op == sfpec_pkg::OP_CLFSR) begin
        fsr[sfpec_pkg::FSR_ERS_ERR] <= 1'b0;
        fsr[sfpec_pkg::FSR_PRG_ERR] <= 1'b0;
        fsr[sfpec_pkg::FSR_PROT]    <= 1'b0;
      end
      if (st == sfpec_pkg::S_PROG || st == sfpec_pkg::S_ERASE) begin
        if (op_timeout_i) begin
          st  <= sfpec_pkg::S_IDLE;
          wip <= 1'b0;
          wel <= 1'b0;
          fsr[sfpec_pkg::FSR_READY] <= 1'b1;
          if (st == sfpec_pkg::S_PROG) begin
            fsr[sfpec_pkg::FSR_PRG_ERR] <= 1'b1;
          end else begin
            fsr[sfpec_pkg::FSR_ERS_ERR] <= 1'b1;
          end
        end else if (tmr != 32'h0) begin
          tmr <= tmr - 32'h1;
        end else if (st == sfpec_pkg::S_ERASE || !f_valid) begin
          st     <= sfpec_pkg::S_IDLE;
          wip    <= 1'b0;
          wel    <= 1'b0;
          fsr[sfpec_pkg::FSR_READY] <= 1'b1;
          ers_go <= (st == sfpec_pkg::S_ERASE);
        end
        if (sel_rise && aligned && op == sfpec_pkg::OP_SUSP) begin
          st        <= sfpec_pkg::S_SUSP;
          susp_prog <= (st == sfpec_pkg::S_PROG);
          wip       <= 1'b0;
          fsr[sfpec_pkg::FSR_READY] <= 1'b1;
          if (st == sfpec_pkg::S_PROG) begin
            fsr[sfpec_pkg::FSR_PRG_SUSP] <= 1'b1;
          end else begin
            fsr[sfpec_pkg::FSR_ERS_SUSP] <= 1'b1;
          end
        end
      end else if (st == sfpec_pkg::S_SUSP) begin
        if (sel_rise && aligned && op == sfpec_pkg::OP_RESUME) begin
          st  <= susp_prog ? sfpec_pkg::S_PROG : sfpec_pkg::S_ERASE;
          wip <= 1'b1;
          fsr[sfpec_pkg::FSR_READY]    <= 1'b0;
          fsr[sfpec_pkg::FSR_PRG_SUSP] <= 1'b0;
          fsr[sfpec_pkg::FSR_ERS_SUSP] <= 1'b0;
        end
      end else if (sel_rise && aligned) begin
        if (op == sfpec_pkg::OP_WREN) begin
          wel <= 1'b1;
        end else if (op == sfpec_pkg::OP_WRDI && !fsr[sfpec_pkg::FSR_PROT]) begin
          wel <= 1'b0;
        end else if (is_prog && wel && byte_cnt == sfpec_pkg::BYTE_DATA) begin
          if (target_locked_i) begin
            fsr[sfpec_pkg::FSR_PROT]    <= 1'b1;
            fsr[sfpec_pkg::FSR_PRG_ERR] <= 1'b1;
          end else begin
            st  <= sfpec_pkg::S_PROG;
            tmr <= PP_CYC;
            wip <= 1'b1;
            fsr[sfpec_pkg::FSR_READY] <= 1'b0;
          end
        end else if (is_erase && wel &&
                     (is_bulk ? byte_cnt == 3'h1 : byte_cnt == sfpec_pkg::BYTE_DATA)) begin
          if (is_bulk ? any_locked_i : target_locked_i) begin
            fsr[sfpec_pkg::FSR_PROT]    <= 1'b1;
            fsr[sfpec_pkg::FSR_ERS_ERR] <= 1'b1;
          end else begin
            st    <= sfpec_pkg::S_ERASE;
            tmr   <= is_bulk ? BE_CYC : (is_sub ? SSE_CYC : SE_CYC);
            wip   <= 1'b1;
            fsr[sfpec_pkg::FSR_READY] <= 1'b0;
            ekind <= is_bulk ? sfpec_pkg::ERS_BULK :
                     (is_sub ? sfpec_pkg::ERS_SUB : sfpec_pkg::ERS_SECT);
            eaddr <= addr;
          end
        end
      end
    end
  end

  // Status stays visible on ports at all times, including while busy.
  assign wel_o          = wel;
  assign wip_o          = wip;
  assign flag_status_o  = fsr;
  assign mem_we_o       = mem_we;
  assign mem_addr_o     = maddr;
  assign mem_clr_mask_o = mclr;
  assign erase_go_o     = ers_go;
  assign erase_kind_o   = ekind;
  assign erase_addr_o   = eaddr;
endmodule

// ---- sfpec_monitor.sv ----
// Concurrent checks on the sequencer's status and memory ports.
`timescale 1ns/1ps
module sfpec_monitor #(
  parameter int unsigned PP_CYC  = 20,
  parameter int unsigned SSE_CYC = 30,
  parameter int unsigned SE_CYC  = 40,
  parameter int unsigned BE_CYC  = 50
) (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       sel_n_i,
  input  wire logic       op_timeout_i,
  input  wire logic       wel_o,
  input  wire logic       wip_o,
  input  wire logic [7:0] flag_status_o,
  input  wire logic       mem_we_o,
  input  wire logic       erase_go_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // Busy and controller-ready always read as opposites.
  busy_ready_a: assert property (wip_o != flag_status_o[7])
    else $error("busy and ready flags agree");
  // Array writes happen only inside a running program.
  write_busy_a: assert property (mem_we_o |-> wip_o)
    else $error("array write while idle");
  // Erase completion leaves the device idle with the latch clear.
  erase_end_a: assert property (erase_go_o |=> !wip_o && !wel_o && !erase_go_o)
    else $error("erase completion did not end the operation");
  // Finishing (not suspending) clears the write enable latch.
  wel_clear_a: assert property ($fell(wip_o) && !flag_status_o[6] && !flag_status_o[2]
    |-> !wel_o)
    else $error("latch kept after operation end");
  // Operations start only after select has risen and with the latch set.
  start_cond_a: assert property ($rose(wip_o) |-> sel_n_i && wel_o)
    else $error("operation started without select high and latch set");
  // A protection error keeps the latch, starts nothing and names its kind.
  prot_err_a: assert property ($rose(flag_status_o[1]) |-> wel_o && !wip_o
    && (flag_status_o[4] || flag_status_o[5]))
    else $error("protection error flags or latch wrong");
  // A timeout ends the operation, clears the latch and sets an error.
  tmo_end_a: assert property (wip_o && op_timeout_i |=> !wip_o && !wel_o
    && (flag_status_o[4] || flag_status_o[5]))
    else $error("timeout handling wrong");
  // The erase error flag rises only from a timeout or a lock.
  erase_cause_a: assert property ($rose(flag_status_o[5])
    |-> $past(op_timeout_i) || flag_status_o[1])
    else $error("erase error without cause");
  // Unused flag bits stay at zero.
  rsvd_zero_a: assert property (flag_status_o[3] == 1'b0 && flag_status_o[0] == 1'b0)
    else $error("reserved flag bit set");

  cover property (erase_go_o);
  cover property (mem_we_o);
  cover property ($rose(flag_status_o[6]));
  cover property ($rose(flag_status_o[1]));
endmodule

bind sfpec_top sfpec_monitor #(
  .PP_CYC(PP_CYC), .SSE_CYC(SSE_CYC), .SE_CYC(SE_CYC), .BE_CYC(BE_CYC)
) i_mon (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sel_n_i(sel_n_i), .op_timeout_i(op_timeout_i),
  .wel_o(wel_o), .wip_o(wip_o), .flag_status_o(flag_status_o), .mem_we_o(mem_we_o),
  .erase_go_o(erase_go_o));

// ---- sfpec_host.sv ----
// Host link controller model that sends frames on select, clock and lanes.
`timescale 1ns/1ps
module sfpec_host (
  input  wire logic       clk_i,
  output logic            sel_n_o,
  output logic            sclk_o,
  output logic [3:0]      dq_o
);
  logic [7:0] b [0:39];
  // Lanes for address and data bytes; zero keeps the frame's own width.
  int         wa = 0;
  int         wd = 0;

  // Select idles high and the serial clock stands low between frames.
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    dq_o = 4'h0;
  end

  // One serial clock period of eight reference clocks, rising in the middle.
  task automatic tick();
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    sclk_o = 1'b0;
  endtask

  // Sends n bytes MSB first, opcode on w lanes, address and data on their own
  // lane counts, then xb stray clocks.
  task automatic xfer(input int w, input int n, input int xb);
    int ln;
    int k;
    @(negedge clk_i);
    sel_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      ln = (i == 0) ? w : (i < 4) ? ((wa != 0) ? wa : w) : ((wd != 0) ? wd : w);
      for (k = 8 - ln; k >= 0; k = k - ln) begin
        dq_o = 4'((b[i] >> k) & ((1 << ln) - 1));
        tick();
      end
    end
    for (int i = 0; i < xb; i++) begin
      dq_o = 4'h5;
      tick();
    end
    repeat (2) @(negedge clk_i);
    sel_n_o = 1'b1;
    dq_o = ~dq_o;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// ---- test_serial_flash_program_erase_control.sv ----
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/1ps
module test_serial_flash_program_erase_control;
  localparam logic [7:0] POP [5] = '{sfpec_pkg::OP_PP, sfpec_pkg::OP_DPP,
    sfpec_pkg::OP_XDPP, sfpec_pkg::OP_QPP, sfpec_pkg::OP_XQPP};
  localparam logic [7:0] EOP [5] = '{sfpec_pkg::OP_SSE_A, sfpec_pkg::OP_SSE_B,
    sfpec_pkg::OP_SE, sfpec_pkg::OP_BE_A, sfpec_pkg::OP_BE_B};
  // Configuration-register write opcode; the sequencer must leave it alone.
  localparam logic [7:0] OP_CFG_WR = 8'hb1;
  logic        clk, nrst, sel_n, sclk, tlk, alk, tmo, rdy, stall, wel, wip, we, go;
  logic [3:0]  dq;
  logic [1:0]  proto, kind;
  logic [7:0]  fsr, mask;
  logic [23:0] maddr, eaddr, a;
  logic [31:0] r, m_ea;
  logic [31:0] r2 = 32'he114;
  logic [31:0] m_wq [$];
  int          num_errors, n_compared, m_wel, m_wip, m_fsr, m_kind, n_go, nd;

  sfpec_top #(.PP_CYC(20), .SSE_CYC(30), .SE_CYC(40), .BE_CYC(50)) i_dut (
    .ref_clk_i(clk), .nrst_i(nrst), .sel_n_i(sel_n), .sclk_i(sclk), .dq_i(dq),
    .proto_i(proto), .target_locked_i(tlk), .any_locked_i(alk), .op_timeout_i(tmo),
    .mem_ready_i(rdy), .wel_o(wel), .wip_o(wip), .flag_status_o(fsr), .mem_we_o(we),
    .mem_addr_o(maddr), .mem_clr_mask_o(mask), .erase_go_o(go), .erase_kind_o(kind),
    .erase_addr_o(eaddr));
  sfpec_host i_host (.clk_i(clk), .sel_n_o(sel_n), .sclk_o(sclk), .dq_o(dq));

  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  // Status ports against the model.
  task automatic st();
    chk(wel, m_wel);
    chk(wip, m_wip);
    chk(fsr, m_fsr);
  endtask

  task automatic setab();
    r = lf(r);
    a = r[23:0];
    i_host.b[1] = a[23:16];
    i_host.b[2] = a[15:8];
    i_host.b[3] = a[7:0];
  endtask

  // One frame on w lanes, then time for select rise to take effect.
  task automatic cmd(input int w, input logic [7:0] op, input int n, input int xb);
    proto = (w == 1) ? sfpec_pkg::PROTO_EXT
      : (w == 2) ? sfpec_pkg::PROTO_DUAL : sfpec_pkg::PROTO_QUAD;
    i_host.b[0] = op;
    i_host.xfer(w, n, xb);
    repeat (2) @(negedge clk);
  endtask

  task automatic idle();
    for (int i = 0; i < 3000 && wip !== 1'b0; i++) @(negedge clk);
    // One more cycle so the completion pulse has been counted.
    @(negedge clk);
    m_wip = 0;
    m_wel = 0;
    m_fsr = 'h80;
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The far side of the write port stalls at random between frames, and always within a frame or while stall is set.
  always @(negedge clk) begin
    r2 <= lf(r2);
    rdy <= sel_n & r2[0] & !stall;
  end

  // Array writes against the expected queue; erase completions against expected kind and, except for bulk, address.
  always @(negedge clk) begin
    if (we === 1'b1 && m_wq.size() == 0) chk(1, 0);
    else if (we === 1'b1) chk({maddr, mask}, m_wq.pop_front());
    if (go === 1'b1) begin
      n_go++;
      chk(kind, m_kind);
      if (m_kind != 2) chk(eaddr, m_ea);
    end
  end

  initial begin
    #3000000;
    num_errors++;
    close_out();
  end

  initial begin
    {nrst, tlk, alk, tmo, stall} = '0;
    proto = 2'h0;
    r = 32'he114;
    {m_wel, m_wip, m_fsr} = {32'd0, 32'd0, 32'h80};
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    st();
    cmd(1, sfpec_pkg::OP_WREN, 1, 0);
    m_wel = 1;
    st();
    cmd(1, sfpec_pkg::OP_WRDI, 1, 0);
    m_wel = 0;
    st();
    setab();
    cmd(2, sfpec_pkg::OP_PP, 5, 0);
    st();
    $display("test 1 done");
    for (int i = 0; i < 5; i++) begin
      cmd(1, sfpec_pkg::OP_WREN, 1, 0);
      setab();
      nd = (i == 4) ? 34 : 3;
      for (int j = 0; j < nd; j++) begin
        r = lf(r);
        i_host.b[4 + j] = r[7:0];
        if (j < 32) m_wq.push_back({a + 24'(j), ~r[7:0]});
      end
      i_host.wd = (i == 0) ? 0 : (i < 3) ? 2 : 4;
      i_host.wa = (i == 2 || i == 4) ? i_host.wd : 0;
      cmd((i == 0) ? 2 : 1, POP[i], 4 + nd, 0);
      {i_host.wa, i_host.wd} = '0;
      {m_wel, m_wip, m_fsr} = {32'd1, 32'd1, 32'h0};
      st();
      idle();
      st();
      chk(m_wq.size(), 0);
    end
    $display("test 2 done");
    cmd(1, sfpec_pkg::OP_WREN, 1, 0);
    m_wel = 1;
    cmd(1, sfpec_pkg::OP_PP, 5, 3);
    st();
    tlk = 1'b1;
    cmd(1, sfpec_pkg::OP_PP, 5, 0);
    m_fsr = 'h92;
    st();
    cmd(1, sfpec_pkg::OP_WRDI, 1, 0);
    st();
    cmd(2, sfpec_pkg::OP_CLFSR, 1, 0);
    m_fsr = 'h80;
    st();
    cmd(1, sfpec_pkg::OP_SE, 4, 0);
    m_fsr = 'ha2;
    st();
    cmd(4, sfpec_pkg::OP_CLFSR, 1, 0);
    tlk = 1'b0;
    alk = 1'b1;
    cmd(1, sfpec_pkg::OP_BE_A, 1, 0);
    st();
    cmd(1, sfpec_pkg::OP_CLFSR, 1, 0);
    alk = 1'b0;
    cmd(1, sfpec_pkg::OP_WRDI, 1, 0);
    {m_wel, m_fsr} = {32'd0, 32'h80};
    st();
    cmd(1, sfpec_pkg::OP_SSE_A, 4, 0);
    st();
    r = lf(r);
    i_host.b[1] = r[7:0];
    i_host.b[2] = r[15:8];
    cmd(1, OP_CFG_WR, 3, 0);
    st();
    $display("test 3 done");
    for (int i = 0; i < 5; i++) begin
      cmd(1, sfpec_pkg::OP_WREN, 1, 0);
      setab();
      m_ea = a;
      m_kind = (i < 2) ? sfpec_pkg::ERS_SUB : (i == 2) ? sfpec_pkg::ERS_SECT : sfpec_pkg::ERS_BULK;
      cmd(1 << (i % 3), EOP[i], (i > 2) ? 1 : 4, 0);
      {m_wel, m_wip, m_fsr} = {32'd1, 32'd1, 32'h0};
      st();
      idle();
      st();
      chk(n_go, i + 1);
    end
    $display("test 4 done");
    cmd(4, sfpec_pkg::OP_WREN, 1, 0);
    m_kind = sfpec_pkg::ERS_SECT;
    cmd(4, sfpec_pkg::OP_SE, 4, 0);
    cmd(4, sfpec_pkg::OP_SUSP, 1, 0);
    {m_wel, m_wip, m_fsr} = {32'd1, 32'd0, 32'hc0};
    st();
    repeat (60) @(negedge clk);
    chk(n_go, 5);
    cmd(4, sfpec_pkg::OP_RESUME, 1, 0);
    {m_wip, m_fsr} = {32'd1, 32'h0};
    st();
    idle();
    st();
    chk(n_go, 6);
    $display("test 5 done");
    stall = 1'b1;
    cmd(1, sfpec_pkg::OP_WREN, 1, 0);
    cmd(4, sfpec_pkg::OP_SE, 4, 0);
    tmo = 1'b1;
    @(negedge clk);
    tmo = 1'b0;
    {m_wel, m_wip, m_fsr} = {32'd0, 32'd0, 32'ha0};
    st();
    cmd(1, sfpec_pkg::OP_WREN, 1, 0);
    cmd(4, sfpec_pkg::OP_PP, 5, 0);
    tmo = 1'b1;
    @(negedge clk);
    tmo = 1'b0;
    m_fsr = 'hb0;
    st();
    cmd(1, sfpec_pkg::OP_CLFSR, 1, 0);
    m_fsr = 'h80;
    st();
    chk(n_go, 6);
    $display("test 6 done");
    close_out();
  end
endmodule
